/* File: d2d_phy_slice.sv */
// one unidirectional die-to-die slice: serdes lanes, alignment, mode strap
// assumes link layer and wires are synchronous to core_clk

`timescale 1ns/1ns
module d2d_phy_slice
  import d2d_pkg::*;
#(
  parameter int         RATIO     = DEF_RATIO,
  parameter bit         SEND      = 1'b1,
  parameter bit         HAS_EXTRA = 1'b1
) (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  phyResetLow,
  input  wire logic [2:0]            rateModeStrap,
  input  wire logic [16*RATIO-1:0]   sendWord,
  input  wire logic [RATIO-1:0]      sendParity,
  input  wire logic [RATIO-1:0]      sendAux,
  output logic                       sendReady,
  output logic [DATA_WIRES+1:0]      wireRiseOut,
  output logic [DATA_WIRES+1:0]      wireFallOut,
  output logic                       fwdClkP,
  output logic                       fwdClkN,
  input  wire logic [DATA_WIRES+1:0] wireRiseIn,
  input  wire logic [DATA_WIRES+1:0] wireFallIn,
  output logic [16*RATIO-1:0]        recvWord,
  output logic [RATIO-1:0]           recvParity,
  output logic [RATIO-1:0]           recvAux,
  output logic                       recvValid,
  output logic                       wordStrobe,
  output logic                       phyReady,
  output logic [9:0]                 sliceGbps,
  output logic [4:0]                 clockGhz
);
  localparam int HALF  = RATIO / 2;
  localparam int PH_W  = $clog2(HALF);
  localparam int WIRES = DATA_WIRES + (HAS_EXTRA ? EXTRA_WIRES : 0);
  localparam int AL_W  = $clog2(ALIGN_WORDS);
  localparam logic [RATIO-1:0] MARKER = {{(RATIO-1){1'b0}}, 1'b1};
  localparam logic [RATIO-1:0] START  = {RATIO{1'b1}};

  logic                     rstAll;
  logic [PH_W-1:0]          phase_q;
  logic                     phaseLast;
  logic                     markerHit;
  d2d_state_t               state_q;
  logic [AL_W-1:0]          alignCnt_q;
  logic [2:0]               mode_q;
  logic                     fwdClk_q;
  logic [9:0]               gbps_q;
  logic [4:0]               ghz_q;
  logic [18*RATIO-1:0]      userFlat;
  logic [18*RATIO-1:0]      viewFlat;
  logic [16*RATIO-1:0]      recvWord_q;
  logic [RATIO-1:0]         recvParity_q;
  logic [RATIO-1:0]         recvAux_q;
  logic                     recvValid_q;
  logic [PH_W:0]            gap_q;
  logic [DATA_WIRES+1:0]    riseAll;
  logic [DATA_WIRES+1:0]    fallAll;

  // ==========================================================
  // reset and word timing
  // either reset holds phase, alignment, lanes and capture; the rate outputs reset on sys_rst only
  assign rstAll    = sys_rst | ~phyResetLow;
  assign phaseLast = (phase_q == PH_W'(HALF - 1));
  assign markerHit = (viewFlat[RATIO-1:0] == MARKER);
  // word strobe is clock over HALF; a receiver still in alignment strobes on a marker hit instead
  assign wordStrobe = (SEND || state_q != ST_ALIGN) ? phaseLast
                                                     : markerHit;

  always_ff @(posedge core_clk)
  begin
    if (rstAll)
      phase_q <= '0;
    else if (wordStrobe)
      phase_q <= '0;
    else
      phase_q <= phase_q + PH_W'(1);
  end

  // ==========================================================
  // alignment sequence
  // self-align after reset release
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      state_q    <= ST_ALIGN;
      alignCnt_q <= '0;
    end
    else if (wordStrobe)
    begin
      case (state_q)
        ST_ALIGN:
        begin
          alignCnt_q <= alignCnt_q + AL_W'(1);
          if (!SEND || alignCnt_q == AL_W'(ALIGN_WORDS - 1))
            state_q <= ST_START;
        end
        ST_START:
        begin
          if (SEND || viewFlat[RATIO-1:0] == START)
            state_q <= ST_RUN;
        end
        ST_RUN:   state_q <= ST_RUN;
        default:  state_q <= ST_ALIGN;
      endcase
    end
  end

  assign phyReady  = (state_q == ST_RUN);
  assign sendReady = SEND && phyReady && wordStrobe;

  // ==========================================================
  // rate mode, caught while reset is held
  // always one defined mode
  // bad strap falls back to 64g
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
      mode_q <= (rateModeStrap < MODE_COUNT) ? rateModeStrap : MODE_RESET;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      gbps_q <= d2d_slice_gbps(MODE_RESET);
      ghz_q  <= d2d_clock_ghz(MODE_RESET);
    end
    else
    begin
      gbps_q <= d2d_slice_gbps(mode_q);
      ghz_q  <= d2d_clock_ghz(mode_q);
    end
  end
  assign sliceGbps = gbps_q;
  assign clockGhz  = ghz_q;

  // ==========================================================
  // forwarded clock
  // complementary pair, sender only
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
      fwdClk_q <= 1'b0;
    else
      fwdClk_q <= ~fwdClk_q;
  end
  assign fwdClkP = SEND & fwdClk_q;
  assign fwdClkN = SEND & ~fwdClk_q;

  // ==========================================================
  // lanes
  // 16 groups of RATIO, extras after
  assign userFlat = {sendAux, sendParity, sendWord};

  genvar gi;
  generate
    for (gi = 0; gi < DATA_WIRES + EXTRA_WIRES; gi++)
    begin : g_lane
      if (gi < WIRES)
      begin : g_used
        logic [RATIO-1:0] laneIn;
        assign laneIn = (state_q == ST_ALIGN) ? MARKER :
                        (state_q == ST_START) ? START  :
                        userFlat[gi*RATIO +: RATIO];
        d2d_lane #(.RATIO(RATIO)) u_lane (
          .core_clk  (core_clk),
          .laneRst   (rstAll),
          .sendMode  (SEND),
          .loadWord  (wordStrobe),
          .parIn     (laneIn),
          .riseIn    (wireRiseIn[gi]),
          .fallIn    (wireFallIn[gi]),
          .riseOut   (riseAll[gi]),
          .fallOut   (fallAll[gi]),
          .shiftView (viewFlat[gi*RATIO +: RATIO])
        );
      end
      else
      begin : g_none
        assign riseAll[gi] = 1'b0;
        assign fallAll[gi] = 1'b0;
        assign viewFlat[gi*RATIO +: RATIO] = '0;
      end
    end
  endgenerate

  assign wireRiseOut = SEND ? riseAll : '0;
  assign wireFallOut = SEND ? fallAll : '0;

  // ==========================================================
  // receive capture
  // receiver path silent when sending
  always_ff @(posedge core_clk)
  begin
    if (rstAll)
    begin
      recvWord_q   <= '0;
      recvParity_q <= '0;
      recvAux_q    <= '0;
      recvValid_q  <= 1'b0;
    end
    else
    begin
      recvValid_q <= !SEND && phyReady && wordStrobe;
      if (!SEND && phyReady && wordStrobe)
      begin
        recvWord_q   <= viewFlat[16*RATIO-1:0];
        recvParity_q <= viewFlat[16*RATIO +: RATIO];
        recvAux_q    <= viewFlat[17*RATIO +: RATIO];
      end
    end
  end
  assign recvWord   = recvWord_q;
  assign recvParity = recvParity_q;
  assign recvAux    = recvAux_q;
  assign recvValid  = recvValid_q;

  // ==========================================================
  // checks
  always_ff @(posedge core_clk)
  begin
    if (rstAll || wordStrobe)
      gap_q <= '0;
    else
      gap_q <= gap_q + (PH_W+1)'(1);
  end

  chk_clock_pair: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    SEND |-> (fwdClkP != fwdClkN))
    else $error("forwarded clock pair not complementary");

  chk_clock_toggle: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (SEND && phyResetLow) ##1 phyResetLow |-> fwdClkP != $past(fwdClkP))
    else $error("forwarded clock stopped");

  chk_reset_hold: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !phyResetLow |=> !phyReady && !recvValid && wireRiseOut == '0)
    else $error("slice active during phy reset");

  chk_word_period: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (wordStrobe && state_q != ST_ALIGN) |-> gap_q == (PH_W+1)'(HALF - 1))
    else $error("word strobe period wrong");

  chk_lsb_first: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    sendReady && phyResetLow ##1 phyResetLow |->
      wireRiseOut[0] == $past(sendWord[0]) &&
      wireFallOut[0] == $past(sendWord[1]))
    else $error("first wire bits are not lowest");

  chk_one_way: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    SEND ? (!recvValid && recvWord == '0) : (wireRiseOut == '0))
    else $error("slice drives both directions");

  chk_mode_legal: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (rstAll && rateModeStrap >= MODE_COUNT) |=> mode_q == MODE_64G)
    else $error("bad rate strap did not fall back");

  chk_extra_pass: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    HAS_EXTRA && sendReady && phyResetLow ##1 phyResetLow |->
      wireRiseOut[16] == $past(sendParity[0]) &&
      wireFallOut[17] == $past(sendAux[1]))
    else $error("extra bits altered");

  cov_ready: cover property (
    @(posedge core_clk) disable iff (sys_rst) $rose(phyReady));
  cov_send_word: cover property (
    @(posedge core_clk) disable iff (sys_rst) sendReady ##HALF sendReady);
  cov_recv_word: cover property (
    @(posedge core_clk) disable iff (sys_rst) recvValid);
  cov_realign: cover property (
    @(posedge core_clk) disable iff (sys_rst) phyReady ##1 !phyResetLow);
endmodule : d2d_phy_slice

/* File: d2d_lane.sv */
// shared constants for the die-to-die slice, plus one wire's serdes lane
// assumes one core clock; each cycle carries a rise bit and a fall bit
//
// Behaviour
// - slice works in one direction only
// - sender drives complementary forwarded clock pair
// - optional parity and auxiliary wires, both or none
// - slice runs in at least one rate mode
// - mode fixes slice, wire and clock rates
// - wires carry bits on both clock edges
// - faster slices also offer 64g mode
// - logic clock is fast clock over two-power
// - logic side moves two bits per wire per cycle
// - parity and aux bits pass untouched
// - logic word is 16 times N bits
// - hold reset while low, then self-align

package d2d_pkg;
  // ==========================================================
  // sizes and clock
  localparam int CLK_MHZ     = 50;
  localparam int DATA_WIRES  = 16;
  localparam int EXTRA_WIRES = 2;
  localparam int DEF_RATIO   = 8;
  localparam int ALIGN_WORDS = 8;

  // ==========================================================
  // rate modes
  localparam logic [2:0] MODE_32G   = 3'h0;
  localparam logic [2:0] MODE_64G   = 3'h1;
  localparam logic [2:0] MODE_128G  = 3'h2;
  localparam logic [2:0] MODE_256G  = 3'h3;
  localparam logic [2:0] MODE_384G  = 3'h4;
  localparam logic [2:0] MODE_512G  = 3'h5;
  localparam logic [2:0] MODE_COUNT = 3'h6;
  localparam logic [2:0] MODE_RESET = MODE_64G;

  typedef enum logic [1:0] {
    ST_ALIGN = 2'b00,
    ST_START = 2'b01,
    ST_RUN   = 2'b10
  } d2d_state_t;

  // slice rate in Gbps per mode
  function automatic logic [9:0] d2d_slice_gbps(input logic [2:0] m);
    case (m)
      MODE_32G:  d2d_slice_gbps = 10'h020;
      MODE_64G:  d2d_slice_gbps = 10'h040;
      MODE_128G: d2d_slice_gbps = 10'h080;
      MODE_256G: d2d_slice_gbps = 10'h100;
      MODE_384G: d2d_slice_gbps = 10'h180;
      MODE_512G: d2d_slice_gbps = 10'h200;
      default:   d2d_slice_gbps = 10'h040;
    endcase
  endfunction : d2d_slice_gbps

  // fast send clock in GHz; wire bit rate is twice this
  function automatic logic [4:0] d2d_clock_ghz(input logic [2:0] m);
    case (m)
      MODE_32G:  d2d_clock_ghz = 5'h01;
      MODE_64G:  d2d_clock_ghz = 5'h02;
      MODE_128G: d2d_clock_ghz = 5'h04;
      MODE_256G: d2d_clock_ghz = 5'h08;
      MODE_384G: d2d_clock_ghz = 5'h0c;
      MODE_512G: d2d_clock_ghz = 5'h10;
      default:   d2d_clock_ghz = 5'h02;
    endcase
  endfunction : d2d_clock_ghz
endpackage : d2d_pkg

`timescale 1ns/1ns
module d2d_lane
  import d2d_pkg::*;
#(
  parameter int RATIO = DEF_RATIO
) (
  input  wire logic             core_clk,
  input  wire logic             laneRst,
  input  wire logic             sendMode,
  input  wire logic             loadWord,
  input  wire logic [RATIO-1:0] parIn,
  input  wire logic             riseIn,
  input  wire logic             fallIn,
  output logic                  riseOut,
  output logic                  fallOut,
  output logic [RATIO-1:0]      shiftView
);
  logic [RATIO-1:0] shift_q;

  // ==========================================================
  // shift two bits per cycle
  always_ff @(posedge core_clk)
  begin
    if (laneRst)
      shift_q <= '0;
    else if (sendMode)
    begin
      if (loadWord)
        shift_q <= parIn;
      else
        shift_q <= {2'b00, shift_q[RATIO-1:2]};
    end
    else
      shift_q <= {fallIn, riseIn, shift_q[RATIO-1:2]};
  end

  assign riseOut   = sendMode & shift_q[0];
  assign fallOut   = sendMode & shift_q[1];
  assign shiftView = shift_q;
endmodule : d2d_lane

/* File: d2d_peer_model.sv */
// peer sending slice that feeds a receiving slice's wire inputs
// assumes core_clk pace and a link layer that loads a word on wantWord
`timescale 1ns/1ns
module d2d_peer_model
  import d2d_pkg::*;
#(
  parameter int RATIO = DEF_RATIO
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic [16*RATIO-1:0] peerWord,
  input  wire logic [RATIO-1:0]    peerParity,
  input  wire logic [RATIO-1:0]    peerAux,
  output logic                     wantWord,
  output logic [DATA_WIRES+1:0]    riseOut,
  output logic [DATA_WIRES+1:0]    fallOut
);
  // ==========================================================
  // training words, then link data
  logic [RATIO-1:0] bits [DATA_WIRES+2];
  int               phaseQ;
  int               wordsQ;

  always_comb
  begin
    for (int w = 0; w < DATA_WIRES + 2; w++)
    begin
      if (wordsQ < ALIGN_WORDS)
        bits[w] = RATIO'(1);
      else if (wordsQ == ALIGN_WORDS)
        bits[w] = '1;
      else if (w < DATA_WIRES)
        bits[w] = peerWord[w*RATIO +: RATIO];
      else
        bits[w] = (w == DATA_WIRES) ? peerParity : peerAux;
    end
  end

  // asked one cycle early so the new word lands on phase 0
  assign wantWord = (phaseQ == RATIO/2 - 1) && (wordsQ >= ALIGN_WORDS);

  // quiet in reset, lowest bit first
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      phaseQ  <= 0;
      wordsQ  <= 0;
      riseOut <= '0;
      fallOut <= '0;
    end
    else
    begin
      for (int w = 0; w < DATA_WIRES + 2; w++)
      begin
        riseOut[w] <= bits[w][2*phaseQ];
        fallOut[w] <= bits[w][2*phaseQ+1];
      end
      phaseQ <= (phaseQ == RATIO/2 - 1) ? 0 : phaseQ + 1;
      if (phaseQ == RATIO/2 - 1 && wordsQ <= ALIGN_WORDS)
        wordsQ <= wordsQ + 1;
    end
  end
endmodule : d2d_peer_model

/* File: testbench.sv */
// self-checking bench: one sending slice, one receiving slice with peer
// assumes both slices share core_clk and the resets
`timescale 1ns/1ns
module testbench;
  import d2d_pkg::*;
  localparam int R = 4;
  localparam int W = 16*R;
  localparam logic [W-1:0] TXW [3] = '{64'h0123_4567_89ab_cdef,
    64'hf0e1_d2c3_b4a5_9687, 64'h5a5a_0ff0_3cc3_a55a};
  localparam logic [W-1:0] RXW [3] = '{64'h1357_9bdf_0246_8ace,
    64'h8000_0000_0000_0001, 64'h6b6b_c0de_7e7e_0102};
  localparam logic [9:0] GB [7] = '{10'h020, 10'h040, 10'h080, 10'h100,
    10'h180, 10'h200, 10'h040};
  localparam logic [4:0] GH [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0c,
    5'h10, 5'h02};
  logic core_clk = 0, sys_rst = 1, phyResetLow = 1, wantWord;
  logic [2:0] strap = 3'h1;
  logic [W-1:0] sendWord = '0, peerWord = '0, rxWord;
  logic [R-1:0] sendPar = '0, sendAux = '0, peerPar = '0, peerAux = '0;
  logic [R-1:0] rxPar, rxAux;
  logic sendReady, txReady, fwdP, fwdN, recvValid, rxReady, rxFwdP;
  logic [17:0] txRise, txFall, peerRise, peerFall, rxWireOut;
  logic txStrobe, rxFwdN;
  logic [17:0] rxWireFall;
  logic [9:0] gbps;
  logic [4:0] ghz;
  int errors, comparisons;

  always #10 core_clk = ~core_clk;

  d2d_phy_slice #(.RATIO(R), .SEND(1'b1)) dut (.core_clk(core_clk),
    .sys_rst(sys_rst), .phyResetLow(phyResetLow), .rateModeStrap(strap),
    .sendWord(sendWord), .sendParity(sendPar), .sendAux(sendAux),
    .sendReady(sendReady), .wireRiseOut(txRise), .wireFallOut(txFall),
    .fwdClkP(fwdP), .fwdClkN(fwdN), .wireRiseIn(peerRise),
    .wireFallIn(peerFall), .recvWord(), .recvParity(), .recvAux(),
    .recvValid(), .wordStrobe(txStrobe),
    .phyReady(txReady), .sliceGbps(gbps), .clockGhz(ghz));
  d2d_phy_slice #(.RATIO(R), .SEND(1'b0)) rxDut (.core_clk(core_clk),
    .sys_rst(sys_rst), .phyResetLow(phyResetLow), .rateModeStrap(strap),
    .sendWord(sendWord), .sendParity(sendPar), .sendAux(sendAux),
    .sendReady(), .wireRiseOut(rxWireOut), .wireFallOut(rxWireFall),
    .fwdClkP(rxFwdP), .fwdClkN(rxFwdN), .wireRiseIn(peerRise),
    .wireFallIn(peerFall),
    .recvWord(rxWord), .recvParity(rxPar), .recvAux(rxAux),
    .recvValid(recvValid), .wordStrobe(), .phyReady(rxReady),
    .sliceGbps(), .clockGhz());
  d2d_peer_model #(.RATIO(R)) peer (.core_clk(core_clk), .sys_rst(sys_rst),
    .peerWord(peerWord), .peerParity(peerPar), .peerAux(peerAux),
    .wantWord(wantWord), .riseOut(peerRise), .fallOut(peerFall));

  // ==========================================================
  // shared helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  function automatic logic [17:0] lane(input logic [W-1:0] w, input int b);
    for (int i = 0; i < DATA_WIRES; i++)
      lane[i] = w[i*R+b];
    lane[16] = w[b];
    lane[17] = ~w[R+b];
  endfunction : lane

  // ==========================================================
  // scenarios
  task automatic tx_stream;
    int n;
    logic p;
    @(posedge core_clk);
    sendWord <= TXW[0];
    sendPar <= TXW[0][R-1:0];
    sendAux <= ~TXW[0][2*R-1:R];
    n = 0;
    @(negedge core_clk);
    while (sendReady !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n == 200)
    begin
      errors++;
      wrap_up();
    end
    check(txRise & txFall, 18'h3ffff);
    p = fwdP;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      sendWord <= TXW[k+1];
      sendPar <= TXW[k+1][R-1:0];
      sendAux <= ~TXW[k+1][2*R-1:R];
      for (int j = 0; j < R/2; j++)
      begin
        @(negedge core_clk);
        check(txRise, lane(TXW[k], 2*j));
        check(txFall, lane(TXW[k], 2*j+1));
        check(sendReady, j == R/2 - 1);
        check(txStrobe, j == R/2 - 1);
        check({fwdP, fwdN}, {~p, p});
        p = fwdP;
      end
    end
  endtask : tx_stream

  task automatic rx_stream;
    int got, want;
    got = 0;
    want = 0;
    for (int c = 0; c < 300 && got < 3; c++)
    begin
      @(negedge core_clk);
      if (c == 0 || recvValid === 1'b1)
        check({rxWireOut, rxWireFall, rxFwdP, rxFwdN}, '0);
      if (recvValid === 1'b1)
      begin
        check(rxReady, 1'b1);
        check(rxWord, RXW[got]);
        check({rxPar, rxAux}, {RXW[got][R-1:0], ~RXW[got][2*R-1:R]});
        got++;
      end
      if (wantWord === 1'b1 && want < 3)
      begin
        @(posedge core_clk);
        peerWord <= RXW[want];
        peerPar <= RXW[want][R-1:0];
        peerAux <= ~RXW[want][2*R-1:R];
        want++;
      end
    end
    check(got, 3);
    if (got != 3)
      wrap_up();
  endtask : rx_stream

  task automatic mode_test;
    for (int m = 0; m < 7; m++)
    begin
      @(posedge core_clk);
      phyResetLow <= 1'b0;
      strap <= 3'(m);
      @(posedge core_clk);
      @(negedge core_clk);
      check({sendReady, txReady, txRise}, '0);
      @(posedge core_clk);
      phyResetLow <= 1'b1;
      repeat (2) @(negedge core_clk);
      check({gbps, ghz}, {GB[m], GH[m]});
    end
  endtask : mode_test

  initial
  begin
    errors = 0;
    comparisons = 0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    fork
      tx_stream();
      rx_stream();
    join
    mode_test();
    wrap_up();
  end
endmodule : testbench
